// ---- logic/mcr_control.sv ----
`timescale 1ns/1ps
// What this block does
// (R1) Register decoded at data offset 0x55 and at I/O offset 0x35.
// (R2) Debug port enabled when disable bit is zero and fuse programmed.
// (R3) Debug-disable bit changes only when same value written twice within four cycles.
// (R4) Software must not alter debug-disable bit while on-chip debug is used.
// (R5) Brown-out sleep-off sets only after unlock write then plain write within four cycles.
// (R6) Sleep-off becomes effective three cycles after set, clears three cycles later.
// (R7) Detector switched off only when sleep executes while sleep-off is active.
// (R8) Global pull-up disable forces every port pull-up off.
// (R9) Vector select zero uses flash start, one uses boot section start.
// (R10) Vector select changes only by unlock write then select write within four cycles.
// (R11) Interrupts blocked from unlock set until after instruction following select write.
// (R12) Without a select write, interrupts stay blocked four cycles then release.
// (R13) Automatic blocking leaves the global interrupt-enable flag untouched.
// (R14) Unlock bit clears four cycles after written or on select write.
// (R15) Boot locks block interrupts in the section not holding the vectors.
// (R16) Vector base is 0x0002 or boot reset address plus 0x0002; reset fuse picks reset.
// (R17) Bits 3 and 2 read zero and ignore writes.
module mcr_control #(
   parameter int ADDR_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] data_addr,
   input wire logic data_wr,
   input wire logic data_rd,
   input wire logic [5:0] io_addr,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata,
   output logic rdata_valid,
   input wire logic debug_port_fuse,
   input wire logic sleep_exec,
   input wire logic [ADDR_W-1:0] boot_reset_addr,
   input wire logic boot_reset_fuse,
   input wire logic app_section_boot_lock,
   input wire logic boot_section_boot_lock,
   input wire logic exec_in_boot,
   input wire logic instr_done,
   output logic debug_port_enable,
   output logic brownout_detector_off,
   output logic pullup_force_off,
   output logic [ADDR_W-1:0] vector_base,
   output logic [ADDR_W-1:0] reset_address,
   output logic irq_block,
   output logic [7:0] mcu_control
);
   import mcr_pkg::*;

   // One decode for both access spaces keeps read and write hits identical
   function automatic logic reg_hit(input logic data_strobe,
                                    input logic [7:0] d_addr,
                                    input logic io_strobe,
                                    input logic [5:0] i_addr);
      logic data_hit;
      logic io_hit;
      data_hit = data_strobe && (d_addr == MCR_DATA_OFFSET);
      io_hit = io_strobe && ({2'b00, i_addr} == MCR_IO_OFFSET);
      return data_hit || io_hit;
   endfunction : reg_hit

   // Interrupts stay off in the section that does not own the vector table while that section's boot lock is set
   function automatic logic section_locked(input logic vec_in_boot,
                                           input logic app_lock,
                                           input logic boot_lock,
                                           input logic in_boot);
      logic app_blocked;
      logic boot_blocked;
      app_blocked = vec_in_boot && app_lock && !in_boot;
      boot_blocked = !vec_in_boot && boot_lock && in_boot;
      return app_blocked || boot_blocked;
   endfunction : section_locked

   logic rst_meta;
   logic rst_sync_n;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   // Both address views hit the same register
   logic hit_wr;
   logic hit_rd;
   assign hit_wr = reg_hit(data_wr, data_addr, io_wr, io_addr); // R1
   assign hit_rd = reg_hit(data_rd, data_addr, io_rd, io_addr); // R1

   logic debug_dis;
   logic bod_off;
   logic bod_unlock;
   logic pullup_dis;
   logic vec_sel;
   logic vec_unlock;

   // Debug-disable: remember a pending value and its window
   logic dbg_pend_val;
   logic dbg_open;
   logic dbg_arm;
   logic dbg_commit;
   assign dbg_commit = hit_wr && dbg_open && (wdata[MCR_BIT_DEBUG_DIS] == dbg_pend_val);
   assign dbg_arm = hit_wr && !dbg_commit;
   mcr_timed_window #(.CYCLES(MCR_WINDOW_CYCLES)) u_dbg_win (
      .mclk(mclk),
      .rst_n(rst_sync_n),
      .arm(dbg_arm),
      .cancel(dbg_commit),
      .open(dbg_open)
   );
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dbg_pend_val <= 1'b0;
         debug_dis <= 1'b0;
      end else begin
         if (dbg_arm) begin
            dbg_pend_val <= wdata[MCR_BIT_DEBUG_DIS];
         end
         if (dbg_commit) begin
            debug_dis <= dbg_pend_val; // R3
         end
      end
   end

   // Brown-out sleep-off unlock window
   logic bod_open;
   logic bod_unlock_wr;
   logic bod_set;
   assign bod_unlock_wr = hit_wr && wdata[MCR_BIT_BOD_OFF] && wdata[MCR_BIT_BOD_UNLOCK];
   assign bod_set = hit_wr && bod_open && wdata[MCR_BIT_BOD_OFF] && !wdata[MCR_BIT_BOD_UNLOCK]; // R5
   mcr_timed_window #(.CYCLES(MCR_WINDOW_CYCLES)) u_bod_win (
      .mclk(mclk),
      .rst_n(rst_sync_n),
      .arm(bod_unlock_wr),
      .cancel(bod_set),
      .open(bod_open)
   );

   // Sleep-off timing: pending delay, then active period, then auto-clear
   // The unlock bit reads one exactly while its four-cycle window is open
   assign bod_unlock = bod_open; // R5

   logic [2:0] bod_cnt;
   logic bod_active;
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         bod_off <= 1'b0;
         bod_cnt <= 3'h0;
         bod_active <= 1'b0;
      end else begin
         if (bod_set) begin
            bod_off <= 1'b1; // R5
            bod_cnt <= 3'(MCR_BOD_DELAY_CYCLES);
            bod_active <= 1'b0;
         end else if (bod_off) begin
            if (bod_cnt != 3'h1) begin
               bod_cnt <= bod_cnt - 3'h1;
            end else if (!bod_active) begin
               bod_active <= 1'b1; // R6
               bod_cnt <= 3'(MCR_BOD_ACTIVE_CYCLES);
            end else begin
               bod_active <= 1'b0; // R6
               bod_off <= 1'b0;
               bod_cnt <= 3'h0;
            end
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         brownout_detector_off <= 1'b0;
      end else if (sleep_exec) begin
         brownout_detector_off <= bod_active; // R7
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         pullup_dis <= 1'b0;
      end else if (hit_wr) begin
         pullup_dis <= wdata[MCR_BIT_PULLUP_DIS];
      end
   end

   // Vector select change sequence
   logic vec_open;
   logic vec_unlock_wr;
   logic vec_commit;
   logic vec_hold;
   assign vec_unlock_wr = hit_wr && wdata[MCR_BIT_VEC_UNLOCK];
   assign vec_commit = hit_wr && vec_open && !wdata[MCR_BIT_VEC_UNLOCK]; // R10
   mcr_timed_window #(.CYCLES(MCR_WINDOW_CYCLES)) u_vec_win (
      .mclk(mclk),
      .rst_n(rst_sync_n),
      .arm(vec_unlock_wr),
      .cancel(vec_commit),
      .open(vec_open)
   );

   // The window itself is the unlock bit: it closes after four cycles or on the select write
   assign vec_unlock = vec_open; // R14

   // A registered copy of the window would hold the bit one cycle too long
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         vec_sel <= 1'b0;
         vec_hold <= 1'b0;
      end else begin
         if (vec_commit) begin
            vec_sel <= wdata[MCR_BIT_VEC_SEL]; // R10
            vec_hold <= 1'b1;
         end else if (vec_hold && instr_done) begin
            vec_hold <= 1'b0; // R11
         end
      end
   end

   // Cycles of blocking left after the unlock write; the write cycle itself
   // is the first of four, so the counter starts one short of the window
   logic [2:0] vec_left;
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         vec_left <= 3'h0;
      end else if (vec_unlock_wr) begin
         vec_left <= 3'(MCR_WINDOW_CYCLES - 1); // R12
      end else if (vec_commit) begin
         vec_left <= 3'h0;
      end else if (vec_left != 3'h0) begin
         vec_left <= vec_left - 3'h1; // R12
      end
   end

   // Block covers unlock window and the instruction after the select write
   logic irq_vec_seq;
   logic irq_lock;
   assign irq_vec_seq = vec_unlock_wr || (vec_left != 3'h0) || vec_commit ||
                        (vec_hold && !instr_done); // R11 R12
   assign irq_lock = section_locked(vec_sel, app_section_boot_lock,
                                    boot_section_boot_lock, exec_in_boot); // R15

   // Only a mask toward the core; the global enable flag is never written here
   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         irq_block <= 1'b0;
      end else begin
         irq_block <= irq_vec_seq || irq_lock; // R13
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         vector_base <= ADDR_W'(MCR_VECTOR_OFFSET);
         reset_address <= ADDR_W'(MCR_APP_START);
      end else begin
         vector_base <= vec_sel ? boot_reset_addr + ADDR_W'(MCR_VECTOR_OFFSET)
                                : ADDR_W'(MCR_VECTOR_OFFSET); // R9 R16
         // Fuse is programmed when low
         reset_address <= boot_reset_fuse ? ADDR_W'(MCR_APP_START) : boot_reset_addr; // R16
      end
   end

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         debug_port_enable <= 1'b0;
         pullup_force_off <= 1'b0;
      end else begin
         // Debug-disable must stay put while on-chip debug runs; software keeps that
         debug_port_enable <= !debug_dis && debug_port_fuse; // R2 R4
         pullup_force_off <= pullup_dis; // R8
      end
   end

   logic [7:0] reg_view;
   assign reg_view = {debug_dis, bod_off, bod_unlock, pullup_dis, 2'b00, vec_sel, vec_unlock} & MCR_IMPL_MASK; // R17

   always_ff @(posedge mclk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rdata <= MCR_RESET;
         rdata_valid <= 1'b0;
         mcu_control <= MCR_RESET;
      end else begin
         rdata_valid <= hit_rd;
         rdata <= hit_rd ? reg_view : 8'h00;
         mcu_control <= reg_view;
      end
   end
endmodule : mcr_control

// ---- pkg/mcr_pkg.sv ----
package mcr_pkg;
   localparam logic [7:0] MCR_DATA_OFFSET = 8'h55;
   localparam logic [7:0] MCR_IO_DELTA = 8'h20;
   localparam logic [7:0] MCR_IO_OFFSET = MCR_DATA_OFFSET - MCR_IO_DELTA;
   localparam logic [7:0] MCR_RESET = 8'h00;
   localparam int MCR_BIT_DEBUG_DIS = 7;
   localparam int MCR_BIT_BOD_OFF = 6;
   localparam int MCR_BIT_BOD_UNLOCK = 5;
   localparam int MCR_BIT_PULLUP_DIS = 4;
   localparam int MCR_BIT_VEC_SEL = 1;
   localparam int MCR_BIT_VEC_UNLOCK = 0;
   localparam logic [7:0] MCR_IMPL_MASK = 8'hf3;
   localparam int MCR_WINDOW_CYCLES = 4;
   localparam int MCR_BOD_DELAY_CYCLES = 3;
   localparam int MCR_BOD_ACTIVE_CYCLES = 3;
   localparam logic [15:0] MCR_VECTOR_OFFSET = 16'h0002;
   localparam logic [15:0] MCR_APP_START = 16'h0000;
   localparam logic [2:0] MCR_CNT_W = 3'h0;
endpackage : mcr_pkg

// ---- logic/mcr_timed_window.sv ----
`timescale 1ns/1ps
// Counts down a fixed number of cycles after being armed; open while counting.
module mcr_timed_window #(
   parameter int CYCLES = 4
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic arm,
   input wire logic cancel,
   output logic open
);
   import mcr_pkg::*;
   logic [3:0] count;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 4'h0;
      end else if (arm) begin
         count <= 4'(CYCLES);
      end else if (cancel) begin
         count <= 4'h0;
      end else if (count != 4'h0) begin
         count <= count - 4'h1;
      end
   end
   assign open = (count != 4'h0);
endmodule : mcr_timed_window

// ---- test/mcr_control_checker.sv ----
`timescale 1ns/1ps
module mcr_control_checker
   import mcr_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [7:0] data_addr,
   input wire logic data_rd,
   input wire logic sleep_exec,
   input wire logic [ADDR_W-1:0] boot_reset_addr,
   input wire logic boot_reset_fuse,
   input wire logic rdata_valid,
   input wire logic debug_port_enable,
   input wire logic brownout_detector_off,
   input wire logic pullup_force_off,
   input wire logic [ADDR_W-1:0] vector_base,
   input wire logic [ADDR_W-1:0] reset_address,
   input wire logic irq_block,
   input wire logic [7:0] mcu_control
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   a_unused_bits_zero: assert property (mcu_control[3:2] == 2'h0) else $error("unused bits set");
   a_read_answer: assert property (data_rd && data_addr == MCR_DATA_OFFSET |=> rdata_valid)
      else $error("read not answered");
   a_debug_port_off: assert property (mcu_control[7] && $past(mcu_control[7]) |-> !debug_port_enable)
      else $error("debug port not disabled");
   a_pullup_forced_off: assert property (mcu_control[4] && $past(mcu_control[4]) |-> pullup_force_off)
      else $error("pull-ups not forced off");
   a_unlock_self_clear: assert property ($rose(mcu_control[0]) |-> ##[1:4] !mcu_control[0])
      else $error("vector unlock not cleared");
   a_unlock_blocks_irq: assert property (mcu_control[0] |-> $past(irq_block))
      else $error("irq not blocked during unlock");
   a_bod_off_span: assert property ($rose(mcu_control[6]) |-> mcu_control[6][*6] ##1 !mcu_control[6])
      else $error("sleep-off span wrong");
   a_sleep_needs_bod: assert property (sleep_exec && !mcu_control[6] |=> !brownout_detector_off)
      else $error("detector off without sleep-off");
   a_vector_base_sel: assert property ($stable(mcu_control[1]) |->
      vector_base == (mcu_control[1] ? boot_reset_addr + MCR_VECTOR_OFFSET : MCR_VECTOR_OFFSET))
      else $error("vector base wrong");
   a_reset_addr_fuse: assert property ($stable(boot_reset_fuse) |->
      reset_address == (boot_reset_fuse ? MCR_APP_START : boot_reset_addr)) else $error("reset address wrong");
   c_vec_moved: cover property ($rose(mcu_control[1]));
   c_bod_off: cover property ($rose(brownout_detector_off));
   c_debug_off: cover property ($fell(debug_port_enable));
endmodule : mcr_control_checker

bind mcr_control mcr_control_checker #(.ADDR_W(ADDR_W)) mcr_control_checker_i (.mclk(mclk), .rst_n(rst_n),
   .data_addr(data_addr), .data_rd(data_rd), .sleep_exec(sleep_exec), .boot_reset_addr(boot_reset_addr),
   .boot_reset_fuse(boot_reset_fuse), .rdata_valid(rdata_valid), .debug_port_enable(debug_port_enable),
   .brownout_detector_off(brownout_detector_off), .pullup_force_off(pullup_force_off),
   .vector_base(vector_base), .reset_address(reset_address), .irq_block(irq_block), .mcu_control(mcu_control));

// ---- test/test_mcu_control_timed_writes.sv ----
`timescale 1ns/1ps
module test_mcu_control_timed_writes;
   import mcr_pkg::*;
   localparam logic [15:0] BOOT = 16'h7c00;
   logic mclk = 1'b0, rst_n = 1'b0, data_wr = 1'b0, data_rd = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   logic [7:0] data_addr = 8'h00, wdata = 8'h00, rdata;
   logic [5:0] io_addr = 6'h00;
   logic fuse = 1'b1, sleep_exec = 1'b0, brst_fuse = 1'b1, instr_done = 1'b0;
   logic rdata_valid, dbg_en, bod_off, pu_off, irq_block;
   logic app_lock = 1'b0, boot_lock = 1'b0, in_boot = 1'b0;
   logic [15:0] vector_base, reset_address;
   int miscompares = 0, check_count = 0;
   mcr_control mcr_control_i (.mclk(mclk), .rst_n(rst_n), .data_addr(data_addr), .data_wr(data_wr),
      .data_rd(data_rd), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .wdata(wdata), .rdata(rdata),
      .rdata_valid(rdata_valid), .debug_port_fuse(fuse), .sleep_exec(sleep_exec), .boot_reset_addr(BOOT),
      .boot_reset_fuse(brst_fuse), .app_section_boot_lock(app_lock), .boot_section_boot_lock(boot_lock),
      .exec_in_boot(in_boot), .instr_done(instr_done), .debug_port_enable(dbg_en), .brownout_detector_off(bod_off),
      .pullup_force_off(pu_off), .vector_base(vector_base), .reset_address(reset_address),
      .irq_block(irq_block), .mcu_control());
   initial begin
      forever #2 mclk = ~mclk;
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(input logic io, input logic [7:0] d);
      @(posedge mclk);
      if (io) begin io_wr <= 1'b1; io_addr <= MCR_IO_OFFSET[5:0]; end
      else begin data_wr <= 1'b1; data_addr <= MCR_DATA_OFFSET; end
      wdata <= d;
      @(posedge mclk);
      data_wr <= 1'b0;
      io_wr <= 1'b0;
   endtask : wr
   task rd(input logic io, input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      if (io) begin io_rd <= 1'b1; io_addr <= a[5:0]; end
      else begin data_rd <= 1'b1; data_addr <= a; end
      @(posedge mclk);
      data_rd <= 1'b0;
      io_rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd
   task tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick
   task finish_test;
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (2000) @(posedge mclk);
      miscompares++;
      finish_test();
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst_n <= 1'b1;
      repeat (3) @(posedge mclk);
      rd(0, MCR_DATA_OFFSET, MCR_RESET);
      rd(0, 8'h56, 8'h00);
      wr(0, 8'h1c);
      rd(1, MCR_IO_OFFSET, 8'h10);
      chk(pu_off, 1);
      wr(1, 8'h00);
      tick(2); chk(pu_off, 0);
      wr(0, 8'h80); repeat (4) @(posedge mclk);
      wr(0, 8'h80); tick(1); chk(dbg_en, 1);
      wr(0, 8'h80);
      rd(0, MCR_DATA_OFFSET, 8'h80);
      chk(dbg_en, 0);
      fuse <= 1'b0; wr(0, 8'h00); wr(0, 8'h00);
      tick(2); chk(dbg_en, 0);
      fuse <= 1'b1; tick(2); chk(dbg_en, 1);
      wr(0, 8'h01); tick(1); chk(irq_block, 1);
      wr(0, 8'h02); tick(2); chk(irq_block, 1);
      instr_done <= 1'b1; @(posedge mclk); instr_done <= 1'b0;
      tick(2); chk(irq_block, 0);
      chk(vector_base, BOOT + MCR_VECTOR_OFFSET);
      rd(0, MCR_DATA_OFFSET, 8'h02);
      wr(0, 8'h03); tick(7); chk(irq_block, 0);
      wr(0, 8'h00); rd(0, MCR_DATA_OFFSET, 8'h02);
      brst_fuse <= 1'b0; tick(3); chk(reset_address, BOOT);
      wr(0, 8'h60); wr(0, 8'h40); repeat (3) @(posedge mclk);
      sleep_exec <= 1'b1; @(posedge mclk); sleep_exec <= 1'b0;
      #1 chk(bod_off, 1);
      wr(0, 8'h40); repeat (3) @(posedge mclk);
      sleep_exec <= 1'b1; @(posedge mclk); sleep_exec <= 1'b0;
      tick(1); chk(bod_off, 0);
      rd(0, MCR_DATA_OFFSET, 8'h02);
      app_lock <= 1'b1; tick(2); chk(irq_block, 1);
      in_boot <= 1'b1; tick(2); chk(irq_block, 0);
      app_lock <= 1'b0; in_boot <= 1'b0;
      finish_test();
   end
endmodule : test_mcu_control_timed_writes
